//--- src/port_vc_arb_pkg.sv
`default_nettype none
package port_vc_arb_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [11:0] OFS_CAP_ONE     = 12'h144;  // Capability word one
  localparam logic [11:0] OFS_CAP_TWO     = 12'h148;  // Capability word two
  localparam logic [11:0] OFS_CTRL_STAT   = 12'h14c;  // Control low half, status high half

  // ****************************************
  // Field positions and constant values
  // ****************************************
  localparam int          EXT_LSB         = 0;        // Extended channel count
  localparam int          LP_LSB          = 4;        // Low-priority group count
  localparam int          REFCLK_LSB      = 8;        // Reference clock encoding
  localparam int          ENTRY_LSB       = 10;       // Table entry size
  localparam int          ARBCAP_LSB      = 0;        // Arbitration capability
  localparam int          TBLOFS_LSB      = 24;       // Table offset, sixteen_byte_unit
  localparam int          LOAD_BIT        = 0;        // Load table control bit
  localparam int          SEL_LSB         = 1;        // Scheme select field
  localparam int          STATUS_BIT      = 16;       // Table pending flag
  localparam logic [1:0]  REFCLK_100NS    = 2'b00;    // 100 ns reference
  localparam logic [1:0]  ENTRY_4BIT      = 2'b10;    // Four-bit table entries
  localparam logic [7:0]  ARBCAP_NONE     = 8'h00;    // No extended channel
  localparam logic [7:0]  ARBCAP_RR_WGT32 = 8'h03;    // Round robin plus weighted_round_robin, 32 phases
  localparam logic [7:0]  TBLOFS_NONE     = 8'h00;    // No table
  localparam logic [7:0]  TBLOFS_ONE      = 8'h03;    // Table at three sixteen_byte_unit
  localparam logic [2:0]  EXT_RESET       = 3'h0;     // Extended count reset value
  localparam logic [2:0]  LP_RESET        = 3'h0;     // Low-priority count reset value
  localparam logic [2:0]  SEL_RESET       = 3'h0;     // Scheme select reset value
  localparam logic [2:0]  SEL_MAX_LEGAL   = 3'h1;     // Highest accepted scheme code
  localparam int          LOAD_CYCLES_DEF = 4;        // Table load duration in cycles

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        valid;   // Access request
    logic        write;   // One for write
    logic [11:0] addr;    // Byte address
    logic [3:0]  be;      // Byte enables
    logic [31:0] wdata;   // Write data
  } cfg_req_t;

  typedef struct packed {
    logic        valid;   // Preload strobe
    logic [2:0]  ext;     // Extended channel count
    logic [2:0]  lp;      // Low-priority group count
  } preload_t;

endpackage
`default_nettype wire

//--- src/port_vc_arbitration_regs.sv
// Notes on behaviour
// - Extended channel count, read-only, preloadable, bits 2:0
// - Low-priority group count, read-only, preloadable, bits 6:4
// - Reference clock code 00b at 9:8
// - Table entry size constant 10b at 11:10
// - Word two advertises round robin, weighted_round_robin only at extended channel count one
// - Arbitration capability follows extended channel count
// - Table offset 00h or 03h by count
// - Load bit triggers load, reads zero
// - Scheme select accepts 0 or 1 only
// - Table write sets pending flag
// - Load completion clears pending flag
`timescale 1ns/1ns
`default_nettype none
module port_vc_arbitration_regs #(
  parameter int LOAD_CYCLES = port_vc_arb_pkg::LOAD_CYCLES_DEF  // Cycles to apply the table
) (
  input  wire logic                      core_clk,     // Core clock, 100 MHz
  input  wire logic                      rst_b,        // Async reset, active low
  input  wire port_vc_arb_pkg::cfg_req_t cfg,          // Configuration access
  output logic [31:0]                    cfg_rdata,    // Read data, registered
  output logic                           cfg_ack,      // Access done, one cycle
  input  wire port_vc_arb_pkg::preload_t preload,      // Serial or boot preload
  input  wire logic                      table_wr,     // Software wrote a table entry
  output logic                           table_apply,  // Start applying table, pulse
  output logic                           table_busy,   // Table load in progress
  output logic [2:0]                     arb_select,   // Active arbitration scheme
  output logic                           table_pending // Table written, not yet loaded
);
  import port_vc_arb_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0]  ext_count;   // Extended channels
    logic [2:0]  lp_count;    // Low-priority group size
    logic [2:0]  arb_sel;     // Scheme select
    logic        tbl_status;  // Table pending
    logic        load_busy;   // Loading
    logic [7:0]  load_cnt;    // Load cycles left
    logic [31:0] rdata;       // Read data
    logic        ack;         // Access ack
    logic        apply;       // Load start pulse
  } state_t;

  state_t q;       // Registered state
  state_t next_q;  // Next state

  logic [31:0] cap_one;     // Capability word one
  logic [31:0] cap_two;     // Capability word two
  logic [31:0] ctrl_stat;   // Control and status word
  logic        hit_ctrl;    // Access to control word
  logic        load_wr;     // Load bit written as one

  // ****************************************
  // Read images
  // ****************************************
  // Field images of the three words, reserved bits zero
  always_comb begin
    cap_one = '0;  // Reserved bits zero
    cap_one[EXT_LSB +: 3] = q.ext_count;
    cap_one[LP_LSB +: 3] = q.lp_count;
    cap_one[REFCLK_LSB +: 2] = REFCLK_100NS;
    cap_one[ENTRY_LSB +: 2] = ENTRY_4BIT;
    cap_two = '0;
    // Arbitration capability follows the extended count
    cap_two[ARBCAP_LSB +: 8] = ARBCAP_NONE;
    if (q.ext_count == 3'h1) begin
      // One extended channel, round robin schemes offered
      cap_two[ARBCAP_LSB +: 8] = ARBCAP_RR_WGT32;
    end
    cap_two[TBLOFS_LSB +: 8] = (q.ext_count == 3'h1) ? TBLOFS_ONE : TBLOFS_NONE;
    ctrl_stat = '0;
    ctrl_stat[SEL_LSB +: 3] = q.arb_sel;
    ctrl_stat[STATUS_BIT] = q.tbl_status;
  end

  // Control word decode, exact byte address
  assign hit_ctrl = cfg.valid && (cfg.addr == OFS_CTRL_STAT);
  assign load_wr  = hit_ctrl && cfg.write && cfg.be[0] && cfg.wdata[LOAD_BIT];

  // ****************************************
  // Next state
  // ****************************************
  // Every request is acked one cycle later
  always_comb begin
    next_q = q;
    next_q.ack = cfg.valid;
    next_q.apply = 1'b0;
    // Read mux, unmapped reads zero
    if (cfg.valid && !cfg.write) begin
      unique case (cfg.addr)
        OFS_CAP_ONE:   next_q.rdata = cap_one;
        OFS_CAP_TWO:   next_q.rdata = cap_two;
        OFS_CTRL_STAT: next_q.rdata = ctrl_stat;
        default:       next_q.rdata = '0;
      endcase
    end
    // Preload of counts
    if (preload.valid) begin
      next_q.ext_count = preload.ext;
      next_q.lp_count = preload.lp;
    end
    // Scheme select write, illegal codes fall back
    if (hit_ctrl && cfg.write && cfg.be[0]) begin
      next_q.arb_sel = (cfg.wdata[SEL_LSB +: 3] <= SEL_MAX_LEGAL) ? cfg.wdata[SEL_LSB +: 3] : SEL_RESET;
    end
    // Load sequencer
    if (load_wr) begin
      next_q.load_busy = 1'b1;
      next_q.load_cnt = 8'(LOAD_CYCLES - 1);
      next_q.apply = 1'b1;
    end else if (q.load_busy) begin
      if (q.load_cnt == 8'h00) begin
        next_q.load_busy = 1'b0;
        next_q.tbl_status = 1'b0;
      end else begin
        next_q.load_cnt = q.load_cnt - 8'h01;
      end
    end
    // Table write wins over completion
    if (table_wr) begin
      next_q.tbl_status = 1'b1;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Reset loads the default counts and scheme
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{ext_count: EXT_RESET, lp_count: LP_RESET, arb_sel: SEL_RESET, default: '0};
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from flip-flops
  assign cfg_rdata     = q.rdata;
  assign cfg_ack       = q.ack;
  assign table_apply   = q.apply;
  assign table_busy    = q.load_busy;
  assign arb_select    = q.arb_sel;
  assign table_pending = q.tbl_status;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  localparam int load_wait_max = LOAD_CYCLES + 1;  // Longest load window

  sequence seq_ctrl_read;
    cfg.valid && !cfg.write && cfg.addr == OFS_CTRL_STAT;
  endsequence

  sequence seq_load_finish;
    q.load_busy && q.load_cnt == 8'h00 && !table_wr && !load_wr;
  endsequence

  // Handshake, ack exactly one cycle after each request
  a_ack_next_cycle: assert property (cfg.valid |=> cfg_ack)
    else $error("ack missing after request");
  a_ack_only_after: assert property (!cfg.valid |=> !cfg_ack)
    else $error("ack without request");
  a_rdata_on_write: assert property (cfg.valid && cfg.write |=> $stable(cfg_rdata))
    else $error("write changed read data");

  // Control and status word image
  a_load_reads_zero: assert property (seq_ctrl_read |=> cfg_rdata[LOAD_BIT] == 1'b0)
    else $error("load bit read as one");
  a_reserved_zero: assert property (seq_ctrl_read |=> cfg_rdata[15:4] == 12'h000 && cfg_rdata[31:17] == 15'h0000)
    else $error("reserved control bits not zero");

  // Capability word images
  a_cap_one_fields: assert property (cfg.valid && !cfg.write && cfg.addr == OFS_CAP_ONE
      |=> cfg_rdata[11:8] == {ENTRY_4BIT, REFCLK_100NS} && cfg_rdata[2:0] == $past(q.ext_count))
    else $error("capability one fields wrong");
  a_cap_one_counts: assert property (cfg.valid && !cfg.write && cfg.addr == OFS_CAP_ONE
      |=> cfg_rdata[6:4] == $past(q.lp_count) && cfg_rdata[3] == 1'b0 && cfg_rdata[7] == 1'b0)
    else $error("capability one count fields wrong");
  a_cap_one_reserved: assert property (cfg.valid && !cfg.write && cfg.addr == OFS_CAP_ONE
      |=> cfg_rdata[31:12] == 20'h00000)
    else $error("capability one reserved bits not zero");
  a_cap_two_dep: assert property (cfg.valid && !cfg.write && cfg.addr == OFS_CAP_TWO
      && q.ext_count == 3'h1 |=> cfg_rdata[7:0] == ARBCAP_RR_WGT32 && cfg_rdata[31:24] == TBLOFS_ONE)
    else $error("capability two not tied to channel count");
  a_cap_two_none: assert property (cfg.valid && !cfg.write && cfg.addr == OFS_CAP_TWO
      && q.ext_count == 3'h0 |=> cfg_rdata == 32'h0000_0000)
    else $error("capability two not zero without extended channel");
  a_cap_two_reserved: assert property (cfg.valid && !cfg.write && cfg.addr == OFS_CAP_TWO
      |=> cfg_rdata[23:8] == 16'h0000)
    else $error("capability two reserved bits not zero");
  a_unmapped_zero: assert property (cfg.valid && !cfg.write && cfg.addr != OFS_CAP_ONE
      && cfg.addr != OFS_CAP_TWO && cfg.addr != OFS_CTRL_STAT |=> cfg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Scheme select
  a_sel_legal: assert property (arb_select <= SEL_MAX_LEGAL)
    else $error("illegal scheme stored");
  a_sel_store: assert property (hit_ctrl && cfg.write && cfg.be[0]
      && cfg.wdata[SEL_LSB +: 3] <= SEL_MAX_LEGAL |=> arb_select == $past(cfg.wdata[SEL_LSB +: 3]))
    else $error("legal scheme not stored");
  a_sel_fallback: assert property (hit_ctrl && cfg.write && cfg.be[0] && cfg.wdata[3:1] > 3'h1
      |=> arb_select == SEL_RESET)
    else $error("illegal scheme not defaulted");

  // Table status flag
  a_status_set: assert property (table_wr |=> table_pending)
    else $error("table write did not set pending");
  a_status_holds: assert property (table_pending && !table_wr && !(q.load_busy && q.load_cnt == 8'h00)
      |=> table_pending)
    else $error("pending dropped before load finished");
  a_status_clear: assert property (seq_load_finish |=> !table_pending && !table_busy)
    else $error("pending not cleared after load");

  // Load sequencer
  a_apply_pulse: assert property (load_wr |=> table_apply && table_busy)
    else $error("load write did not start the sequencer");
  a_apply_one_cycle: assert property (table_apply && !load_wr |=> !table_apply)
    else $error("apply pulse longer than one cycle");
  a_load_bounded: assert property (load_wr ##1 (!load_wr) [*1] |-> ##[0:load_wait_max] !table_busy || load_wr)
    else $error("table load did not finish");

  // Count preload
  a_preload_counts: assert property (preload.valid |=> q.ext_count == $past(preload.ext) && q.lp_count == $past(preload.lp))
    else $error("preload not taken");

endmodule
`default_nettype wire

//--- sim/test_port_vc_arbitration_regs.sv
`timescale 1ns/1ns
`default_nettype none
module test_port_vc_arbitration_regs;
  import port_vc_arb_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  localparam int LC = 2;     // Shortened load time
  logic        core_clk;     // Core clock
  logic        rst_b;        // Reset, active low
  cfg_req_t    cfg;          // Config access
  logic [31:0] cfg_rdata;    // Read data
  logic        cfg_ack;      // Access done
  preload_t    preload;      // Count preload
  logic        table_wr;     // Table entry written
  logic        table_apply;  // Load pulse
  logic        table_busy;   // Load running
  logic [2:0]  arb_select;   // Active scheme
  logic        table_pending;// Pending flag
  int          error_cnt;    // Mismatches
  int          checks;       // Comparisons
  int          cyc = 0;      // Timeout counter
  int          k;            // Loop index

  port_vc_arbitration_regs #(.LOAD_CYCLES(LC)) port_vc_arbitration_regs_inst (
    .core_clk(core_clk), .rst_b(rst_b), .cfg(cfg), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack), .preload(preload), .table_wr(table_wr),
    .table_apply(table_apply), .table_busy(table_busy),
    .arb_select(arb_select), .table_pending(table_pending));

  // Clock, 10 ns period
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Cut a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: run timed out", $time);
      wrap_up();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up;
    if (error_cnt == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One access, data taken in the ack cycle
  task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] be,
                     input logic [31:0] d, output logic [31:0] rd);
    @(posedge core_clk);
    cfg <= '{valid: 1'b1, write: w, addr: a, be: be, wdata: d};
    @(posedge core_clk);
    cfg.valid <= 1'b0;
    #1;
    chk({31'h0, cfg_ack}, 32'h1);
    rd = cfg_rdata;
  endtask

  // Read and compare
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    acc(1'b0, a, 4'h0, 32'h0, v);
    chk(v, exp);
  endtask

  // Write
  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] v;
    acc(1'b1, a, be, d, v);
  endtask

  // Preload strobe
  task automatic pl(input logic [2:0] e, input logic [2:0] l);
    @(posedge core_clk);
    preload <= '{valid: 1'b1, ext: e, lp: l};
    @(posedge core_clk);
    preload.valid <= 1'b0;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_b = 1'b0;
    cfg = '0;
    preload = '0;
    table_wr = 1'b0;
    error_cnt = 0;
    checks = 0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(OFS_CAP_ONE, 32'h0000_0800);
    rd(OFS_CAP_TWO, 32'h0);
    rd(OFS_CTRL_STAT, 32'h0);
    pl(3'h1, 3'h1);
    rd(OFS_CAP_ONE, 32'h0000_0811);
    rd(OFS_CAP_TWO, 32'h0300_0003);
    wr(OFS_CAP_TWO, 4'hf, 32'h0);
    rd(OFS_CAP_TWO, 32'h0300_0003);
    pl(3'h7, 3'h7);
    rd(OFS_CAP_ONE, 32'h0000_0877);
    rd(OFS_CAP_TWO, 32'h0);
    rd(12'h150, 32'h0);
    // Every scheme code, illegal ones fall back
    for (k = 0; k < 8; k++) begin
      wr(OFS_CTRL_STAT, 4'h1, {28'h0, k[2:0], 1'b0});
      rd(OFS_CTRL_STAT, {28'h0, (k < 2) ? k[2:0] : 3'h0, 1'b0});
      chk({29'h0, arb_select}, (k < 2) ? k : 0);
    end
    wr(OFS_CTRL_STAT, 4'h0, 32'h2);
    rd(OFS_CTRL_STAT, 32'h0);
    // Table write, then load
    @(posedge core_clk);
    table_wr <= 1'b1;
    @(posedge core_clk);
    table_wr <= 1'b0;
    #1;
    chk({31'h0, table_pending}, 32'h1);
    rd(OFS_CTRL_STAT, 32'h0001_0000);
    wr(OFS_CTRL_STAT, 4'h1, 32'hffff_ffff);
    chk({30'h0, table_apply, table_busy}, 32'h3);
    repeat (LC - 1) @(posedge core_clk);
    #1;
    chk({30'h0, table_apply, table_pending}, 32'h1);
    @(posedge core_clk);
    #1;
    chk({30'h0, table_busy, table_pending}, 32'h0);
    rd(OFS_CTRL_STAT, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
